// >>> core/cpu_exec_pkg.sv
// Constants, encodings and types of the call/clear/complement execute block
package cpu_exec_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int PC_W    = 21;
  localparam int DATA_W  = 8;
  localparam int DADDR_W = 12;
  localparam int BANK_W  = 4;
  localparam int INSTR_W = 16;
  localparam int BUS_AW  = 8;
  localparam int BUS_DW  = 32;

  // ****************************************
  // Opcode patterns
  // ****************************************
  localparam logic [7:0]  OP_BRANCH_HI = 8'he0;
  localparam logic [6:0]  OP_CALL1_TOP = 7'h76;
  localparam logic [3:0]  OP_CALL2_TOP = 4'hf;
  localparam logic [6:0]  OP_CLEAR_TOP = 7'h35;
  localparam logic [15:0] OP_KICK_WORD = 16'h0004;
  localparam logic [5:0]  OP_INV_TOP   = 6'h07;

  // ****************************************
  // Field positions and data layout
  // ****************************************
  localparam int BIT_BANK_SEL = 8;
  localparam int BIT_DEST     = 9;
  localparam int FLAG_Z       = 2;
  localparam int FLAG_N       = 4;
  localparam logic [7:0]        ACCESS_SPLIT   = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [PC_W-1:0]   PC_STEP        = 21'h000002;
  localparam logic [PC_W-1:0]   RET_OFS        = 21'h000004;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [BUS_AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [BUS_AW-1:0] OFS_PC       = 8'h04;
  localparam logic [BUS_AW-1:0] OFS_ACC      = 8'h08;
  localparam logic [BUS_AW-1:0] OFS_FLAGS    = 8'h0c;
  localparam logic [BUS_AW-1:0] OFS_BANK     = 8'h10;
  localparam logic [BUS_AW-1:0] OFS_ACC_SH   = 8'h14;
  localparam logic [BUS_AW-1:0] OFS_FLAGS_SH = 8'h18;
  localparam logic [BUS_AW-1:0] OFS_BANK_SH  = 8'h1c;
  localparam logic [BUS_AW-1:0] OFS_STK_TOP  = 8'h20;
  localparam logic [BUS_AW-1:0] OFS_STK_PTR  = 8'h24;
  localparam logic [BUS_AW-1:0] OFS_POWER    = 8'h28;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [PC_W-1:0]   PC_RST    = 21'h000000;
  localparam logic [7:0]        ACC_RST   = 8'h00;
  localparam logic [7:0]        FLAGS_RST = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RST  = 4'h0;
  localparam logic              PWR_RST   = 1'h1;
  localparam int                STACK_DEPTH_DEF = 31;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00, PH_Q2 = 2'b01, PH_Q3 = 2'b10, PH_Q4 = 2'b11
  } phase_e;

  typedef enum logic [1:0] {
    CY_NORMAL = 2'b00, CY_IDLE = 2'b01, CY_CALL2 = 2'b10
  } cycle_e;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000, OP_BRANCH = 3'b001, OP_CALL   = 3'b010,
    OP_CLEAR  = 3'b011, OP_KICK   = 3'b100, OP_INVERT = 3'b101
  } op_e;

endpackage : cpu_exec_pkg

// >>> core/phase_if.sv
// Phase handshake between the execute core and its phase sequencer
interface phase_if;
  cpu_exec_pkg::phase_e phase;
  logic                 advance;
  modport seq  (output phase, input advance);
  modport core (input phase, output advance);
endinterface : phase_if

// >>> core/phase_sequencer.sv
// Four-phase sequencer of the instruction cycle
module phase_sequencer (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  phase_if.seq      ph
);

  typedef struct packed {
    cpu_exec_pkg::phase_e phase;
  } seq_s;

  seq_s r;
  seq_s n;

  // ****************************************
  // Phase step
  // ****************************************
  always_comb begin
    n = r;
    if (ph.advance) begin
      case (r.phase)
        cpu_exec_pkg::PH_Q1: n.phase = cpu_exec_pkg::PH_Q2;
        cpu_exec_pkg::PH_Q2: n.phase = cpu_exec_pkg::PH_Q3;
        cpu_exec_pkg::PH_Q3: n.phase = cpu_exec_pkg::PH_Q4;
        default:             n.phase = cpu_exec_pkg::PH_Q1;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r.phase <= cpu_exec_pkg::PH_Q1;
    end else begin
      r <= n;
    end
  end

  assign ph.phase = r.phase;

endmodule : phase_sequencer

// >>> core/cpu_call_clear_complement_exec.sv
// Execute core for branch-if-null, call, clear, watchdog kick and invert
// Operation
// - Branch adds twice offset when null set
// - Taken branch two cycles, untaken one
// - Call reaches whole 2 Mbyte space
// - Call pushes address plus four first
// - Context bit set copies to shadows
// - Context bit clear keeps shadows
// - Target loads counter bits 20:1
// - Call is two words, fixed prefixes
// - Call takes two cycles, push first
// - Clear writes zero, sets null flag
// - Bank bit zero selects access bank
// - Bank bit one uses bank select
// - Kick resets watchdog and postscaler
// - Invert operand, update msb, null flags
// - Target bit zero writes accumulator
// - Target bit one writes memory
module cpu_call_clear_complement_exec #(
  parameter int STACK_DEPTH = cpu_exec_pkg::STACK_DEPTH_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  busAddr,
  input  wire logic [31:0] busWdata,
  input  wire logic        busWrite,
  input  wire logic        busRead,
  output logic      [31:0] busRdata,
  output logic      [20:0] progAddr,
  input  wire logic [15:0] progData,
  output logic      [11:0] dataAddr,
  output logic             dataRead,
  input  wire logic [7:0]  dataRdata,
  output logic             dataWrite,
  output logic      [7:0]  dataWdata,
  output logic             watchdogClear
);

  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  if (STACK_DEPTH < 1 || STACK_DEPTH > 255) begin : g_depth_check
    $error("STACK_DEPTH must lie in 1..255");
  end

  typedef struct packed {
    logic                             running;
    logic                             ctrlRun;
    cpu_exec_pkg::cycle_e             cycle;
    cpu_exec_pkg::op_e                op;
    logic [15:0]                      instr;
    logic [20:0]                      pc;
    logic [20:0]                      instrAddr;
    logic [7:0]                       acc;
    logic [7:0]                       flags;
    logic [3:0]                       bank;
    logic [7:0]                       accSh;
    logic [7:0]                       flagsSh;
    logic [3:0]                       bankSh;
    logic [SP_W-1:0]                  sp;
    logic [STACK_DEPTH-1:0][20:0]     stack;
    logic [7:0]                       kLow;
    logic                             ctxCopy;
    logic [11:0]                      dAddr;
    logic [7:0]                       operand;
    logic [7:0]                       result;
    logic                             toDest;
    logic                             timeout;
    logic                             sleep;
    logic                             kick;
    logic [31:0]                      rdata;
  } state_s;

  state_s r;
  state_s n;
  phase_if ph ();

  phase_sequencer u_phase (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ph      (ph.seq)
  );

  // ****************************************
  // Functions
  // ****************************************
  function automatic cpu_exec_pkg::op_e decode(input logic [15:0] w);
    if (w[15:8] == cpu_exec_pkg::OP_BRANCH_HI) begin
      return cpu_exec_pkg::OP_BRANCH;
    end else if (w[15:9] == cpu_exec_pkg::OP_CALL1_TOP) begin
      return cpu_exec_pkg::OP_CALL;
    end else if (w[15:9] == cpu_exec_pkg::OP_CLEAR_TOP) begin
      return cpu_exec_pkg::OP_CLEAR;
    end else if (w == cpu_exec_pkg::OP_KICK_WORD) begin
      return cpu_exec_pkg::OP_KICK;
    end else if (w[15:10] == cpu_exec_pkg::OP_INV_TOP) begin
      return cpu_exec_pkg::OP_INVERT;
    end
    return cpu_exec_pkg::OP_NONE;
  endfunction : decode

  function automatic logic [11:0] dataAddress(input logic [7:0] f,
                                              input logic       sel,
                                              input logic [3:0] bsel);
    if (!sel) begin
      return {(f < cpu_exec_pkg::ACCESS_SPLIT) ? cpu_exec_pkg::ACCESS_LO_BANK
                                               : cpu_exec_pkg::ACCESS_HI_BANK, f};
    end
    return {bsel, f};
  endfunction : dataAddress

  function automatic logic [20:0] stackTop(input state_s s);
    if (s.sp == '0) begin
      return '0;
    end
    return s.stack[s.sp - SP_W'(1)];
  endfunction : stackTop

  // ****************************************
  // Next state
  // ****************************************
  logic [20:0] brOfs;
  logic        memOp;
  assign brOfs = {{12{r.instr[7]}}, r.instr[7:0], 1'b0};
  assign memOp = (r.op == cpu_exec_pkg::OP_CLEAR) || (r.op == cpu_exec_pkg::OP_INVERT);
  always_comb begin
    n = r;
    n.kick = 1'b0;
    n.rdata = '0;
    // Bus writes; core registers only while halted
    if (busWrite) begin
      case (busAddr)
        cpu_exec_pkg::OFS_CTRL:  n.ctrlRun = busWdata[0];
        cpu_exec_pkg::OFS_POWER: begin
          n.timeout = busWdata[0];
          n.sleep = busWdata[1];
        end
        default: begin
        end
      endcase
    end
    if (busWrite && !r.running) begin
      case (busAddr)
        cpu_exec_pkg::OFS_PC:    n.pc = {busWdata[20:1], 1'b0};
        cpu_exec_pkg::OFS_ACC:   n.acc = busWdata[7:0];
        cpu_exec_pkg::OFS_FLAGS: n.flags = busWdata[7:0];
        cpu_exec_pkg::OFS_BANK:  n.bank = busWdata[3:0];
        default: begin
        end
      endcase
    end
    if (busRead) begin
      case (busAddr)
        cpu_exec_pkg::OFS_CTRL:     n.rdata = {30'h0, r.running, r.ctrlRun};
        cpu_exec_pkg::OFS_PC:       n.rdata = 32'(r.pc);
        cpu_exec_pkg::OFS_ACC:      n.rdata = 32'(r.acc);
        cpu_exec_pkg::OFS_FLAGS:    n.rdata = 32'(r.flags);
        cpu_exec_pkg::OFS_BANK:     n.rdata = 32'(r.bank);
        cpu_exec_pkg::OFS_ACC_SH:   n.rdata = 32'(r.accSh);
        cpu_exec_pkg::OFS_FLAGS_SH: n.rdata = 32'(r.flagsSh);
        cpu_exec_pkg::OFS_BANK_SH:  n.rdata = 32'(r.bankSh);
        cpu_exec_pkg::OFS_STK_TOP:  n.rdata = 32'(stackTop(r));
        cpu_exec_pkg::OFS_STK_PTR:  n.rdata = 32'(r.sp);
        cpu_exec_pkg::OFS_POWER:    n.rdata = {30'h0, r.sleep, r.timeout};
        default:                    n.rdata = '0;
      endcase
    end
    if (!r.running) begin
      n.running = r.ctrlRun;
    end else begin
      case (ph.phase)
        cpu_exec_pkg::PH_Q1: begin
          case (r.cycle)
            cpu_exec_pkg::CY_NORMAL: begin
              n.instr = progData;
              n.instrAddr = r.pc;
              n.pc = r.pc + cpu_exec_pkg::PC_STEP;
              n.op = decode(progData);
              n.dAddr = dataAddress(progData[7:0], progData[cpu_exec_pkg::BIT_BANK_SEL],
                                    r.bank);
              n.toDest = progData[cpu_exec_pkg::BIT_DEST];
              n.kLow = progData[7:0];
              n.ctxCopy = progData[cpu_exec_pkg::BIT_BANK_SEL];
            end
            cpu_exec_pkg::CY_CALL2: begin
              n.instr = progData;
              n.pc = r.pc + cpu_exec_pkg::PC_STEP;
            end
            default: begin
              n.op = cpu_exec_pkg::OP_NONE;
            end
          endcase
        end
        cpu_exec_pkg::PH_Q3: begin
          case (r.op)
            cpu_exec_pkg::OP_INVERT: begin
              n.operand = dataRdata;
              n.result = ~dataRdata;
            end
            cpu_exec_pkg::OP_CLEAR: begin
              n.result = 8'h00;
            end
            cpu_exec_pkg::OP_KICK: begin
              n.kick = 1'b1;
            end
            cpu_exec_pkg::OP_CALL: begin
              if (r.cycle == cpu_exec_pkg::CY_NORMAL) begin
                if (r.sp < SP_W'(STACK_DEPTH)) begin
                  n.stack[r.sp] = r.instrAddr + cpu_exec_pkg::RET_OFS;
                  n.sp = r.sp + SP_W'(1);
                end else begin
                  n.stack[STACK_DEPTH-1] = r.instrAddr + cpu_exec_pkg::RET_OFS;
                end
                if (r.ctxCopy) begin
                  n.accSh = r.acc;
                  n.flagsSh = r.flags;
                  n.bankSh = r.bank;
                end
              end
            end
            default: begin
            end
          endcase
        end
        cpu_exec_pkg::PH_Q4: begin
          n.cycle = cpu_exec_pkg::CY_NORMAL;
          case (r.op)
            cpu_exec_pkg::OP_BRANCH: begin
              if (r.cycle == cpu_exec_pkg::CY_NORMAL && r.flags[cpu_exec_pkg::FLAG_Z]) begin
                n.pc = r.pc + brOfs;
                n.cycle = cpu_exec_pkg::CY_IDLE;
              end
            end
            cpu_exec_pkg::OP_CALL: begin
              if (r.cycle == cpu_exec_pkg::CY_NORMAL) begin
                n.cycle = cpu_exec_pkg::CY_CALL2;
              end else begin
                n.pc = {r.instr[11:0], r.kLow, 1'b0};
              end
            end
            cpu_exec_pkg::OP_CLEAR: begin
              n.flags[cpu_exec_pkg::FLAG_Z] = 1'b1;
            end
            cpu_exec_pkg::OP_INVERT: begin
              n.flags[cpu_exec_pkg::FLAG_Z] = (r.result == 8'h00);
              n.flags[cpu_exec_pkg::FLAG_N] = r.result[7];
              if (!r.toDest) begin
                n.acc = r.result;
              end
            end
            cpu_exec_pkg::OP_KICK: begin
              n.timeout = 1'b1;
              n.sleep = 1'b1;
            end
            default: begin
            end
          endcase
          // Halt only on an instruction boundary
          if (n.cycle == cpu_exec_pkg::CY_NORMAL) begin
            n.running = r.ctrlRun;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.pc <= cpu_exec_pkg::PC_RST;
      r.acc <= cpu_exec_pkg::ACC_RST;
      r.flags <= cpu_exec_pkg::FLAGS_RST;
      r.bank <= cpu_exec_pkg::BANK_RST;
      r.timeout <= cpu_exec_pkg::PWR_RST;
      r.sleep <= cpu_exec_pkg::PWR_RST;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ph.advance = r.running;
  assign busRdata = r.rdata;
  assign progAddr = r.pc;
  assign dataAddr = r.dAddr;
  assign dataWdata = r.result;
  assign watchdogClear = r.kick;
  assign dataRead = r.running && ph.phase == cpu_exec_pkg::PH_Q2 && memOp;
  assign dataWrite = r.running && ph.phase == cpu_exec_pkg::PH_Q4
                     && (r.op == cpu_exec_pkg::OP_CLEAR
                         || (r.op == cpu_exec_pkg::OP_INVERT && r.toDest));

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence atQ4(cpu_exec_pkg::op_e o);
    r.running && ph.phase == cpu_exec_pkg::PH_Q4 && r.op == o;
  endsequence
  sequence callFirst;
    r.running && ph.phase == cpu_exec_pkg::PH_Q3 && r.op == cpu_exec_pkg::OP_CALL
    && r.cycle == cpu_exec_pkg::CY_NORMAL;
  endsequence
  sequence branchTaken;
    atQ4(cpu_exec_pkg::OP_BRANCH) ##0
    (r.cycle == cpu_exec_pkg::CY_NORMAL && r.flags[cpu_exec_pkg::FLAG_Z]);
  endsequence
  branch_pc_a: assert property (
    branchTaken |=> r.pc == $past(r.pc) + $past(brOfs))
    else $error("taken branch target wrong");
  branch_idle_a: assert property (
    branchTaken |=> (r.cycle == cpu_exec_pkg::CY_IDLE && !dataWrite && !watchdogClear)[*4]
    ##1 r.cycle == cpu_exec_pkg::CY_NORMAL)
    else $error("taken branch idle cycle missing");
  branch_skip_a: assert property (
    atQ4(cpu_exec_pkg::OP_BRANCH) ##0 !r.flags[cpu_exec_pkg::FLAG_Z]
    |=> $stable(r.pc) && r.cycle == cpu_exec_pkg::CY_NORMAL)
    else $error("untaken branch changed flow");
  call_target_a: assert property (
    callFirst |-> ##6 (r.pc == {r.instr[11:0], r.kLow, 1'b0} && !r.pc[0]
    && r.instr[15:12] == cpu_exec_pkg::OP_CALL2_TOP))
    else $error("call target not loaded after two cycles");
  push_return_a: assert property (
    callFirst |=> stackTop(r) == r.instrAddr + cpu_exec_pkg::RET_OFS)
    else $error("return address not pushed");
  shadow_copy_a: assert property (
    callFirst ##0 r.ctxCopy |=> r.accSh == $past(r.acc) && r.flagsSh == $past(r.flags)
    && r.bankSh == $past(r.bank))
    else $error("shadow copy missing");
  shadow_keep_a: assert property (
    callFirst ##0 !r.ctxCopy |=> $stable(r.accSh) && $stable(r.flagsSh) && $stable(r.bankSh))
    else $error("shadows changed without copy bit");
  clear_zero_a: assert property (
    atQ4(cpu_exec_pkg::OP_CLEAR) |-> dataWrite && dataWdata == 8'h00
    ##1 r.flags[cpu_exec_pkg::FLAG_Z])
    else $error("clear did not write zero and set null");
  access_bank_a: assert property (
    dataRead && !r.instr[cpu_exec_pkg::BIT_BANK_SEL]
    |-> dataAddr[11:8] == (r.instr[7] ? 4'hf : 4'h0) && dataAddr[7:0] == r.instr[7:0])
    else $error("access bank address wrong");
  bank_select_a: assert property (
    dataRead && r.instr[cpu_exec_pkg::BIT_BANK_SEL] |-> dataAddr == {r.bank, r.instr[7:0]})
    else $error("banked address wrong");
  kick_flags_a: assert property (
    r.running && ph.phase == cpu_exec_pkg::PH_Q3 && r.op == cpu_exec_pkg::OP_KICK
    |=> watchdogClear ##1 (r.timeout && r.sleep && !watchdogClear))
    else $error("watchdog kick sequence wrong");
  invert_acc_a: assert property (
    atQ4(cpu_exec_pkg::OP_INVERT) ##0 !r.toDest
    |-> !dataWrite ##1 (r.acc == ~r.operand && r.flags[cpu_exec_pkg::FLAG_N] == ~r.operand[7]))
    else $error("invert to accumulator wrong");
  invert_mem_a: assert property (
    atQ4(cpu_exec_pkg::OP_INVERT) ##0 r.toDest |-> dataWrite && dataWdata == ~r.operand
    ##1 r.flags[cpu_exec_pkg::FLAG_Z] == (r.operand == 8'hff))
    else $error("invert to memory wrong");
  single_cycle_a: assert property (
    r.running && ph.phase == cpu_exec_pkg::PH_Q2 && memOp
    |-> ##2 (ph.phase == cpu_exec_pkg::PH_Q4 ##1 r.cycle == cpu_exec_pkg::CY_NORMAL))
    else $error("single cycle instruction overran");
endmodule : cpu_call_clear_complement_exec

// >>> tb/tb.sv
// Self-checking testbench of the call/clear/complement execute block
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk       = 1'b0;
  logic        rst_n         = 1'b0;
  logic [7:0]  busAddr       = 8'h00;
  logic [31:0] busWdata      = 32'h00000000;
  logic        busWrite      = 1'b0;
  logic        busRead       = 1'b0;
  logic [31:0] busRdata;
  logic [20:0] progAddr;
  logic [15:0] progData;
  logic [11:0] dataAddr;
  logic        dataRead;
  logic [7:0]  dataRdata     = 8'h00;
  logic        dataWrite;
  logic [7:0]  dataWdata;
  logic        watchdogClear;
  logic [15:0] prog [int];
  logic [7:0]  dmem [4096];
  int          wTimes [$];
  int          kTimes [$];
  int          cyc           = 0;
  int          n_errors      = 0;
  int          tests_run     = 0;

  cpu_call_clear_complement_exec i_dut (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .busAddr       (busAddr),
    .busWdata      (busWdata),
    .busWrite      (busWrite),
    .busRead       (busRead),
    .busRdata      (busRdata),
    .progAddr      (progAddr),
    .progData      (progData),
    .dataAddr      (dataAddr),
    .dataRead      (dataRead),
    .dataRdata     (dataRdata),
    .dataWrite     (dataWrite),
    .dataWdata     (dataWdata),
    .watchdogClear (watchdogClear)
  );

  always #5 ref_clk = ~ref_clk;

  // ****************************************
  // Program and data memories
  // ****************************************
  always @* begin
    progData = prog.exists(int'(progAddr)) ? prog[int'(progAddr)] : 16'h0000;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (dataRead) dataRdata <= dmem[dataAddr];
    if (dataWrite) dmem[dataAddr] <= dataWdata;
    if (dataWrite) wTimes.push_back(cyc);
    if (watchdogClear) kTimes.push_back(cyc);
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    busAddr  <= a;
    busWdata <= d;
    busWrite <= 1'b1;
    @(posedge ref_clk);
    busWrite <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge ref_clk);
    busRead <= 1'b0;
    #1 d = busRdata;
  endtask : bus_read

  task automatic read_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus_read(a, v);
    check(what, exp, v);
  endtask : read_check

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    read_check("ctrl", cpu_exec_pkg::OFS_CTRL, 32'h0);
    read_check("pc", cpu_exec_pkg::OFS_PC, 32'h0);
    read_check("power", cpu_exec_pkg::OFS_POWER, 32'h3);
    read_check("acc shadow", cpu_exec_pkg::OFS_ACC_SH, 32'h0);
    read_check("stack ptr", cpu_exec_pkg::OFS_STK_PTR, 32'h0);
  endtask : test_reset

  task automatic test_bus_map();
    bus_write(8'h30, 32'hffffffff);
    read_check("unmapped", 8'h30, 32'h0);
    bus_write(cpu_exec_pkg::OFS_ACC_SH, 32'h000000ff);
    read_check("acc shadow ro", cpu_exec_pkg::OFS_ACC_SH, 32'h0);
    bus_write(cpu_exec_pkg::OFS_ACC, 32'h000001ab);
    read_check("acc narrow", cpu_exec_pkg::OFS_ACC, 32'h000000ab);
    bus_write(cpu_exec_pkg::OFS_PC, 32'h00000007);
    read_check("pc bit0", cpu_exec_pkg::OFS_PC, 32'h00000006);
  endtask : test_bus_map

  task automatic test_program();
    logic [31:0] v;
    dmem[12'hf90] = 8'h5a;
    dmem[12'h020] = 8'h13;
    dmem[12'h210] = 8'h77;
    dmem[12'h211] = 8'h55;
    dmem[12'h030] = 8'h99;
    bus_write(cpu_exec_pkg::OFS_BANK, 32'h2);
    bus_write(cpu_exec_pkg::OFS_FLAGS, 32'h0);
    bus_write(cpu_exec_pkg::OFS_POWER, 32'h0);
    bus_write(cpu_exec_pkg::OFS_PC, 32'h0);
    bus_write(cpu_exec_pkg::OFS_CTRL, 32'h1);
    for (int i = 0; i < 400 && wTimes.size() < 3; i++) @(posedge ref_clk);
    bus_write(cpu_exec_pkg::OFS_CTRL, 32'h0);
    v = 32'h2;
    for (int i = 0; i < 40 && v[1] !== 1'b0; i++) bus_read(cpu_exec_pkg::OFS_CTRL, v);
    check("halted", 32'h0, v);
    check("inv to acc keeps mem", 32'h5a, 32'(dmem[12'hf90]));
    check("inv to mem", 32'hec, 32'(dmem[12'h020]));
    check("clear banked", 32'h0, 32'(dmem[12'h210]));
    check("branch skip", 32'h55, 32'(dmem[12'h211]));
    check("clear access", 32'h0, 32'(dmem[12'h030]));
    read_check("pc", cpu_exec_pkg::OFS_PC, 32'h001ffff2);
    read_check("acc", cpu_exec_pkg::OFS_ACC, 32'h13);
    read_check("flags", cpu_exec_pkg::OFS_FLAGS, 32'h04);
    read_check("acc shadow", cpu_exec_pkg::OFS_ACC_SH, 32'ha5);
    read_check("flags shadow", cpu_exec_pkg::OFS_FLAGS_SH, 32'h14);
    read_check("bank shadow", cpu_exec_pkg::OFS_BANK_SH, 32'h2);
    read_check("stack top", cpu_exec_pkg::OFS_STK_TOP, 32'h88);
    read_check("stack ptr", cpu_exec_pkg::OFS_STK_PTR, 32'h2);
    read_check("power", cpu_exec_pkg::OFS_POWER, 32'h3);
    check("kick pulses", 32'h1, 32'(kTimes.size()));
    check("writes", 32'h3, 32'(wTimes.size()));
    if (kTimes.size() == 1 && wTimes.size() == 3) begin
      check("one cycle op", 32'd4, 32'(wTimes[1] - wTimes[0]));
      check("taken branch", 32'd12, 32'(kTimes[0] - wTimes[1]));
      check("call cycles", 32'd28, 32'(wTimes[2] - kTimes[0]));
    end
  endtask : test_program

  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    prog[32'h000000] = 16'h1c90;
    prog[32'h000002] = 16'h1e20;
    prog[32'h000004] = 16'h6b10;
    prog[32'h000006] = 16'he002;
    prog[32'h000008] = 16'h6b11;
    prog[32'h00000a] = 16'h6b11;
    prog[32'h00000c] = 16'h0004;
    prog[32'h00000e] = 16'hed40;
    prog[32'h000010] = 16'hf000;
    prog[32'h000080] = 16'h1c20;
    prog[32'h000082] = 16'he040;
    prog[32'h000084] = 16'hecf8;
    prog[32'h000086] = 16'hffff;
    prog[32'h1ffff0] = 16'h6a30;
    prog[32'h1ffff2] = 16'he0ff;
    for (int i = 0; i < 4096; i++) dmem[i] = 8'h00;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_reset();
    test_bus_map();
    test_program();
    summarize();
  end

  initial begin
    #200000;
    n_errors++;
    summarize();
  end

endmodule : tb
